/* fbc_core.v */
// Architectural resources of the 4-bit controller core behind an AXI4-Lite slave.
// Functional notes
// - RAM is addressed by a row field and a 4-bit column field.
// - RAM holds 6 rows of 16 nibbles; row pointer is 3 bits.
// - Row and column pointers load separately and read back together in one register; column increments and decrements.
// - Flag and seven working registers live in the last RAM row.
// - Carry is set, cleared and tested directly, and set by the carry-out of ADDC and ADDS.
// - A carry-save flip-flop copies and holds the carry.
// - Program counter is 11 bits and holds the executing address.
// - Program counter advances sequentially; jump and call load a target.
// - Call pushes the incremented program counter onto a 3-entry 11-bit stack.
// - Interrupt test skips the next instruction when the interrupt flag is set.
// - Interrupt test clears the interrupt flag.
// - Accepted hardware interrupt pushes the stack and calls the interrupt routine.
// - Timer is a 6-bit polynomial prescaler driving a 6-bit down counter.
// - Timer start loads the down counter and begins timing for a nonzero count; a zero count sets the timer flag at once.
// - Prescaler decrements the down counter every 63 instruction cycles.
// - Down counter reaching zero sets the timer flag.
// - Timer test skips the next instruction when the timer flag is set.
// - Ports A, B input; C, D bidirectional; E to H output; I 3-bit output.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "fbc_regs.vh"
module fbc_core #(
  parameter [7:0] INSTR_DIV = 8'd4
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address.
  input wire awvalid,
  output wire awready,
  input wire [7:0] awaddr,
  // AXI4-Lite write data.
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response.
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address.
  input wire arvalid,
  output wire arready,
  input wire [7:0] araddr,
  // AXI4-Lite read data.
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Input ports and interrupt request.
  input wire [3:0] port_a,
  input wire [3:0] port_b,
  input wire int_pin,
  // Bidirectional ports.
  input wire [3:0] port_c_in,
  output reg [3:0] port_c_out,
  output reg [3:0] port_c_oe,
  input wire [3:0] port_d_in,
  output reg [3:0] port_d_out,
  output reg [3:0] port_d_oe,
  // Output ports.
  output reg [3:0] port_e,
  output reg [3:0] port_f,
  output reg [3:0] port_g,
  output reg [3:0] port_h,
  output reg [2:0] port_i
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_EXEC = 2'h2;
  localparam [1:0] ST_RESP = 2'h3;
  localparam STACK_DEPTH = 3;

  // Core state.
  reg [3:0] acc;
  reg carry;
  reg carry_save;
  reg [2:0] row_pointer;
  reg [3:0] column_pointer;
  reg [10:0] pc;
  reg [10:0] stk [0:STACK_DEPTH-1];
  reg [1:0] depth;
  reg int_ff;
  reg int_en;
  reg timer_ff;
  reg timer_run;
  reg [5:0] tcount;
  reg [5:0] lfsr;
  reg [7:0] div_cnt;
  reg skip;
  reg [1:0] state;
  // Bus holding registers.
  reg aw_held;
  reg [7:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg w_lane0;
  // Synchronisers for everything arriving from pins.
  reg [16:0] sync1;
  reg [16:0] sync2;
  reg int_prev;
  integer k;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 17'h00000;
      sync2 <= 17'h00000;
      int_prev <= 1'b0;
    end else begin
      sync1 <= {int_pin, port_a, port_b, port_c_in, port_d_in};
      sync2 <= sync1;
      int_prev <= sync2[16];
    end
  end

  wire int_edge = sync2[16] & ~int_prev;
  wire [3:0] in_a = sync2[15:12];
  wire [3:0] in_b = sync2[11:8];
  wire [3:0] in_c = sync2[7:4];
  wire [3:0] in_d = sync2[3:0];

  // Command decode.
  wire [4:0] op = w_data[`FBC_CMD_OP];
  wire [10:0] arg = w_data[`FBC_CMD_ARG];
  wire live = (state == ST_EXEC) && !skip;
  wire is_wreg = (op == `FBC_OP_WLD) || (op == `FBC_OP_WST);
  wire [3:0] wcol = (arg[2:0] == `FBC_FLAG_IDX) ? `FBC_FLAG_COL : {1'b0, arg[2:0]};
  wire [3:0] col_inc = column_pointer + 4'h1;
  wire [3:0] col_dec = column_pointer - 4'h1;
  wire [10:0] pc_inc = pc + 11'h001;

  // RAM address and write enable.
  wire [6:0] ram_addr = is_wreg ? {`FBC_LAST_ROW, wcol} : {row_pointer, column_pointer};
  wire [3:0] ram_rd;
  wire ram_we = live && ((op == `FBC_OP_STM) || (op == `FBC_OP_XCH) || (op == `FBC_OP_XCHI) ||
    (op == `FBC_OP_XCHD) || (op == `FBC_OP_WST));

  fbc_ram #(
    .WORDS(`FBC_RAM_WORDS),
    .AW(7),
    .DW(4)
  ) u_ram (
    .clk(aclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(acc),
    .rdata(ram_rd)
  );

  wire use_c = (op == `FBC_OP_ADDC) || (op == `FBC_OP_ADDS);
  wire [4:0] sum = {1'b0, acc} + {1'b0, ram_rd} + {4'h0, use_c & carry};

  // Instruction cycle enable and polynomial prescaler.
  wire instr_tick = (div_cnt == INSTR_DIV - 8'd1);
  wire [5:0] next_lfsr = {lfsr[4:0], lfsr[5] ^ lfsr[4]};
  wire pre_pulse = instr_tick && timer_run && (next_lfsr == `FBC_LFSR_SEED);
  wire tstart = live && (op == `FBC_OP_TSTART);

  // Selected input port.
  reg [3:0] port_sel;
  always @* begin
    case (arg[3:0])
      `FBC_PSEL_A: port_sel = in_a;
      `FBC_PSEL_B: port_sel = in_b;
      `FBC_PSEL_C: port_sel = in_c;
      `FBC_PSEL_D: port_sel = in_d;
      default: port_sel = 4'h0;
    endcase
  end

  // Register read mux.
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (araddr)
      `FBC_OFF_CMD: rd_mux = w_data;
      `FBC_OFF_STATUS: rd_mux = {19'h00000, depth, timer_run, skip, timer_ff, int_ff, 1'b0,
        carry_save, carry, acc};
      `FBC_OFF_PTR: rd_mux = {25'h0000000, row_pointer, column_pointer};
      `FBC_OFF_PC: rd_mux = {21'h000000, pc};
      `FBC_OFF_TIMER: rd_mux = {18'h00000, lfsr, 2'h0, tcount};
      `FBC_OFF_PIN: rd_mux = {16'h0000, in_d, in_c, in_b, in_a};
      `FBC_OFF_POUT: rd_mux = {5'h00, port_i, port_h, port_g, port_f, port_e, port_d_out,
        port_c_out};
      `FBC_OFF_DIR: rd_mux = {24'h000000, port_d_oe, port_c_oe};
      `FBC_OFF_INTC: rd_mux = {31'h00000000, int_en};
      default: rd_hit = 1'b0;
    endcase
  end

  reg wr_hit;
  always @* begin
    case (aw_addr)
      `FBC_OFF_CMD, `FBC_OFF_STATUS, `FBC_OFF_PTR, `FBC_OFF_PC, `FBC_OFF_TIMER,
      `FBC_OFF_PIN, `FBC_OFF_POUT, `FBC_OFF_DIR, `FBC_OFF_INTC: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;

  // Read channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `FBC_RESP_OKAY;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else if (arvalid) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? `FBC_RESP_OKAY : `FBC_RESP_SLVERR;
    end
  end

  // Write channel, command execution, stack, timer and interrupt flags.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FBC_RESP_OKAY;
      state <= ST_IDLE;
      acc <= `FBC_RST_NIB;
      carry <= 1'b0;
      carry_save <= 1'b0;
      row_pointer <= 3'h0;
      column_pointer <= `FBC_RST_NIB;
      pc <= `FBC_RST_PC;
      for (k = 0; k < STACK_DEPTH; k = k + 1) begin
        stk[k] <= `FBC_RST_PC;
      end
      depth <= 2'h0;
      int_ff <= 1'b0;
      int_en <= 1'b0;
      timer_ff <= 1'b0;
      timer_run <= 1'b0;
      tcount <= 6'h00;
      lfsr <= `FBC_LFSR_SEED;
      div_cnt <= 8'h00;
      skip <= 1'b0;
      port_c_out <= `FBC_RST_NIB;
      port_c_oe <= `FBC_RST_NIB;
      port_d_out <= `FBC_RST_NIB;
      port_d_oe <= `FBC_RST_NIB;
      port_e <= `FBC_RST_NIB;
      port_f <= `FBC_RST_NIB;
      port_g <= `FBC_RST_NIB;
      port_h <= `FBC_RST_NIB;
      port_i <= 3'h0;
    end else begin
      div_cnt <= instr_tick ? 8'h00 : div_cnt + 8'd1;
      if (awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_lane0 <= wstrb[0];
      end
      // Prescaler and down counter; a fresh start takes over the count.
      if (instr_tick && timer_run) begin
        lfsr <= next_lfsr;
      end
      if (pre_pulse && !tstart) begin
        tcount <= tcount - 6'h01;
        if (tcount == 6'h01) begin
          timer_run <= 1'b0;
        end
      end
      case (state)
        ST_IDLE: begin
          if (int_en && int_ff) begin
            for (k = STACK_DEPTH - 1; k > 0; k = k - 1) begin
              stk[k] <= stk[k-1];
            end
            stk[0] <= pc;
            if (depth != `FBC_STACK_FULL) begin
              depth <= depth + 2'h1;
            end
            pc <= `FBC_INT_VECTOR;
            int_ff <= 1'b0;
            int_en <= 1'b0;
          end else if (aw_held && w_held) begin
            if (aw_addr == `FBC_OFF_CMD) begin
              state <= ST_WAIT;
            end else begin
              if (aw_addr == `FBC_OFF_DIR && w_lane0) begin
                port_c_oe <= w_data[`FBC_DIR_C];
                port_d_oe <= w_data[`FBC_DIR_D];
              end
              if (aw_addr == `FBC_OFF_INTC && w_lane0) begin
                int_en <= w_data[`FBC_INTC_EN];
              end
              bvalid <= 1'b1;
              bresp <= wr_hit ? `FBC_RESP_OKAY : `FBC_RESP_SLVERR;
              state <= ST_RESP;
            end
          end
        end
        ST_WAIT: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          bvalid <= 1'b1;
          bresp <= `FBC_RESP_OKAY;
          state <= ST_RESP;
          pc <= pc_inc;
          skip <= 1'b0;
          if (!skip) begin
            case (op)
              `FBC_OP_LDI: acc <= arg[3:0];
              `FBC_OP_LDM: acc <= ram_rd;
              `FBC_OP_XCH: acc <= ram_rd;
              `FBC_OP_XCHI: begin
                acc <= ram_rd;
                column_pointer <= col_inc;
                skip <= (col_inc == 4'h0);
              end
              `FBC_OP_XCHD: begin
                acc <= ram_rd;
                column_pointer <= col_dec;
                skip <= (col_dec == 4'hf);
              end
              `FBC_OP_ADD: begin
                acc <= sum[3:0];
                skip <= sum[4];
              end
              `FBC_OP_ADDC, `FBC_OP_ADDS: begin
                acc <= sum[3:0];
                if (sum[4]) begin
                  carry <= 1'b1;
                end
                skip <= (op == `FBC_OP_ADDS) && sum[4];
              end
              `FBC_OP_SETC: carry <= 1'b1;
              `FBC_OP_CLRC: carry <= 1'b0;
              `FBC_OP_TSTC: skip <= carry;
              `FBC_OP_SAVC: carry_save <= carry;
              `FBC_OP_RSTC: carry <= carry_save;
              `FBC_OP_SROW: row_pointer <= arg[2:0];
              `FBC_OP_SCOL: column_pointer <= arg[3:0];
              `FBC_OP_A2COL: column_pointer <= acc;
              `FBC_OP_COL2A: acc <= column_pointer;
              `FBC_OP_INCC: begin
                column_pointer <= col_inc;
                skip <= (col_inc == 4'h0);
              end
              `FBC_OP_DECC: begin
                column_pointer <= col_dec;
                skip <= (col_dec == 4'hf);
              end
              `FBC_OP_JUMP: pc <= arg;
              `FBC_OP_CALL: begin
                for (k = STACK_DEPTH - 1; k > 0; k = k - 1) begin
                  stk[k] <= stk[k-1];
                end
                stk[0] <= pc_inc;
                if (depth != `FBC_STACK_FULL) begin
                  depth <= depth + 2'h1;
                end
                pc <= arg;
              end
              `FBC_OP_RET: begin
                pc <= stk[0];
                for (k = 0; k < STACK_DEPTH - 1; k = k + 1) begin
                  stk[k] <= stk[k+1];
                end
                if (depth != 2'h0) begin
                  depth <= depth - 2'h1;
                end
              end
              `FBC_OP_ITEST: begin
                skip <= int_ff;
                int_ff <= 1'b0;
              end
              `FBC_OP_TSTART: begin
                tcount <= arg[5:0];
                timer_run <= (arg[5:0] != 6'h00);
                timer_ff <= (arg[5:0] == 6'h00);
                lfsr <= `FBC_LFSR_SEED;
              end
              `FBC_OP_TTEST: skip <= timer_ff;
              `FBC_OP_POUT: begin
                case (arg[3:0])
                  `FBC_PSEL_C: port_c_out <= acc;
                  `FBC_PSEL_D: port_d_out <= acc;
                  `FBC_PSEL_E: port_e <= acc;
                  `FBC_PSEL_F: port_f <= acc;
                  `FBC_PSEL_G: port_g <= acc;
                  `FBC_PSEL_H: port_h <= acc;
                  `FBC_PSEL_I: port_i <= acc[2:0];
                  default: port_i <= port_i;
                endcase
              end
              `FBC_OP_PIN: acc <= port_sel;
              `FBC_OP_WLD: acc <= ram_rd;
              default: acc <= acc;
            endcase
          end
        end
        ST_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // Hardware events win over clears made in the same cycle.
      if (pre_pulse && tcount == 6'h01) begin
        timer_ff <= 1'b1;
      end
      if (int_edge) begin
        int_ff <= 1'b1;
      end
    end
  end
endmodule // fbc_core

/* fbc_regs.vh */
// Register offsets, field positions, command codes and reset values of the controller core.
`ifndef FBC_REGS_VH
`define FBC_REGS_VH
`define FBC_OFF_CMD 8'h00
`define FBC_OFF_STATUS 8'h04
`define FBC_OFF_PTR 8'h08
`define FBC_OFF_PC 8'h0c
`define FBC_OFF_TIMER 8'h10
`define FBC_OFF_PIN 8'h14
`define FBC_OFF_POUT 8'h18
`define FBC_OFF_DIR 8'h1c
`define FBC_OFF_INTC 8'h20
`define FBC_CMD_OP 4:0
`define FBC_CMD_ARG 26:16
`define FBC_DIR_C 3:0
`define FBC_DIR_D 7:4
`define FBC_INTC_EN 0
`define FBC_OP_NOP 5'h00
`define FBC_OP_LDI 5'h01
`define FBC_OP_LDM 5'h02
`define FBC_OP_STM 5'h03
`define FBC_OP_XCH 5'h04
`define FBC_OP_XCHI 5'h05
`define FBC_OP_XCHD 5'h06
`define FBC_OP_ADD 5'h07
`define FBC_OP_ADDC 5'h08
`define FBC_OP_ADDS 5'h09
`define FBC_OP_SETC 5'h0a
`define FBC_OP_CLRC 5'h0b
`define FBC_OP_TSTC 5'h0c
`define FBC_OP_SAVC 5'h0d
`define FBC_OP_RSTC 5'h0e
`define FBC_OP_SROW 5'h0f
`define FBC_OP_SCOL 5'h10
`define FBC_OP_A2COL 5'h11
`define FBC_OP_COL2A 5'h12
`define FBC_OP_INCC 5'h13
`define FBC_OP_DECC 5'h14
`define FBC_OP_JUMP 5'h15
`define FBC_OP_CALL 5'h16
`define FBC_OP_RET 5'h17
`define FBC_OP_ITEST 5'h18
`define FBC_OP_TSTART 5'h19
`define FBC_OP_TTEST 5'h1a
`define FBC_OP_POUT 5'h1b
`define FBC_OP_PIN 5'h1c
`define FBC_OP_WLD 5'h1d
`define FBC_OP_WST 5'h1e
`define FBC_PSEL_A 4'h0
`define FBC_PSEL_B 4'h1
`define FBC_PSEL_C 4'h2
`define FBC_PSEL_D 4'h3
`define FBC_PSEL_E 4'h4
`define FBC_PSEL_F 4'h5
`define FBC_PSEL_G 4'h6
`define FBC_PSEL_H 4'h7
`define FBC_PSEL_I 4'h8
`define FBC_RST_NIB 4'h0
`define FBC_RST_PC 11'h000
`define FBC_INT_VECTOR 11'h040
`define FBC_LFSR_SEED 6'h3f
`define FBC_LAST_ROW 3'h5
`define FBC_FLAG_IDX 3'h6
`define FBC_FLAG_COL 4'hf
`define FBC_RAM_WORDS 96
`define FBC_STACK_FULL 2'h3
`define FBC_RESP_OKAY 2'h0
`define FBC_RESP_SLVERR 2'h2
`endif

/* fbc_ram.v */
// Data RAM of the controller core with registered read data.
`timescale 1ns/100ps
module fbc_ram #(
  parameter WORDS = 96,
  parameter AW = 7,
  parameter DW = 4
) (
  // Clock.
  input wire clk,
  // Access port.
  input wire we,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);
  localparam [AW:0] LIMIT = WORDS[AW:0];
  reg [DW-1:0] mem [0:WORDS-1];
  wire in_range = ({1'b0, addr} < LIMIT);

  // Addresses past the last row write nothing and read as zero.
  always @(posedge clk) begin
    if (we && in_range) begin
      mem[addr] <= wdata;
    end
    if (in_range) begin
      rdata <= mem[addr];
    end else begin
      rdata <= {DW{1'b0}};
    end
  end
endmodule // fbc_ram

/* fbc_core_sva.sv */
// Concurrent checks on the ports of the controller core.
`timescale 1ns/100ps
`include "fbc_regs.vh"
module fbc_core_sva #(
  parameter [7:0] INSTR_DIV = 8'd4
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Write channels.
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [1:0] bresp,
  // Read channels.
  input wire arvalid,
  input wire arready,
  input wire [7:0] araddr,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  // Output port.
  input wire [3:0] port_e
);
  reg [7:0] last_ar;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always @(posedge aclk) begin
    if (!aresetn) last_ar <= 8'h00;
    else if (arvalid && arready) last_ar <= araddr;
  end
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_ar_busy: assert property (rvalid |-> !arready) else $error("read taken while busy");
  a_r_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  a_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##[2:5] bvalid)
    else $error("write answer late");
  a_w_block: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
  a_unmapped_read: assert property (arvalid && arready && araddr > 8'h20
    |=> rresp == `FBC_RESP_SLVERR && rdata == 32'h0) else $error("unmapped read answered");
  a_ptr_width: assert property (rvalid && last_ar == `FBC_OFF_PTR |-> rdata[31:7] == 25'h0)
    else $error("pointer wider than row and column");
  a_pc_width: assert property (rvalid && last_ar == `FBC_OFF_PC |-> rdata[31:11] == 21'h0)
    else $error("program counter wider than eleven bits");
  a_timer_width: assert property (rvalid && last_ar == `FBC_OFF_TIMER
    |-> rdata[31:14] == 18'h0 && rdata[7:6] == 2'h0) else $error("timer fields too wide");
  a_out_exec: assert property ($past(aresetn) && $changed(port_e) |-> $rose(bvalid))
    else $error("output port moved outside a command");
endmodule // fbc_core_sva
bind fbc_core fbc_core_sva #(.INSTR_DIV(INSTR_DIV)) u_sva (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .port_e(port_e));

/* fbc_pins_model.sv */
// Model of the external circuitry on the parallel ports.
`timescale 1ns/100ps
module fbc_pins_model (
  // Values presented by the outside world.
  input wire [3:0] a_val,
  input wire [3:0] b_val,
  input wire [3:0] c_ext,
  input wire [3:0] d_ext,
  input wire irq,
  // Device drive of the two-way ports.
  input wire [3:0] port_c_out,
  input wire [3:0] port_c_oe,
  input wire [3:0] port_d_out,
  input wire [3:0] port_d_oe,
  // Levels seen by the device.
  output wire [3:0] port_a,
  output wire [3:0] port_b,
  output wire [3:0] port_c_in,
  output wire [3:0] port_d_in,
  output wire int_pin
);
  assign port_a = a_val;
  assign port_b = b_val;
  assign int_pin = irq;
  // A two-way line shows the device value where it drives, the outside value elsewhere.
  assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & c_ext);
  assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & d_ext);
endmodule // fbc_pins_model

/* test_fbc_core.sv */
// Self-checking testbench of the controller core.
`timescale 1ns/100ps
`include "fbc_regs.vh"
`define CHK(nm, xp, gt) begin checks_done = checks_done + 1; if ((gt) !== (xp)) begin \
  errors = errors + 1; $display("unexpected %s exp %0h got %0h", nm, xp, gt); end end
module test_fbc_core;
  reg aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, irq = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, d;
  reg [3:0] wstrb = 4'h0, pa = 4'h0, pb = 4'h0, c_ext = 4'h0, d_ext = 4'h0;
  reg [1:0] r;
  integer errors = 0, checks_done = 0, cycles = 0;
  wire awready, wready, bvalid, arready, rvalid, int_pin;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] port_a, port_b, port_c_in, port_c_out, port_c_oe, port_d_in, port_d_out;
  wire [3:0] port_d_oe, port_e, port_f, port_g, port_h;
  wire [2:0] port_i;
  fbc_core #(.INSTR_DIV(8'd1)) u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .port_a(port_a), .port_b(port_b), .int_pin(int_pin),
    .port_c_in(port_c_in), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
    .port_d_in(port_d_in), .port_d_out(port_d_out), .port_d_oe(port_d_oe), .port_e(port_e),
    .port_f(port_f), .port_g(port_g), .port_h(port_h), .port_i(port_i));
  fbc_pins_model u_pins (.a_val(pa), .b_val(pb), .c_ext(c_ext), .d_ext(d_ext), .irq(irq),
    .port_c_out(port_c_out), .port_c_oe(port_c_oe), .port_d_out(port_d_out),
    .port_d_oe(port_d_oe), .port_a(port_a), .port_b(port_b), .port_c_in(port_c_in),
    .port_d_in(port_d_in), .int_pin(int_pin));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task end_sim;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  task wr(input [7:0] a, input [31:0] v);
    reg ta, tw, tb;
    begin
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
        @(negedge aclk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        tb = bvalid;
        r = bresp;
        @(posedge aclk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
      end
    end
  endtask
  task rd(input [7:0] a);
    reg ta, tr;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
        @(negedge aclk);
        ta = arvalid && arready;
        tr = rvalid;
        d = rdata;
        r = rresp;
        @(posedge aclk);
        if (ta) arvalid <= 1'b0;
      end
    end
  endtask
  task ex(input [4:0] op, input [10:0] arg);
    wr(`FBC_OFF_CMD, {5'h0, arg, 11'h0, op});
  endtask
  task pulse;
    begin
      irq <= 1'b1;
      repeat (3) @(posedge aclk);
      irq <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask
  task t_reset;
    begin
      rd(`FBC_OFF_STATUS);
      `CHK("status", 32'h0, d)
      rd(`FBC_OFF_PC);
      `CHK("pc", 32'h0, d)
      rd(8'h40);
      `CHK("bad read", `FBC_RESP_SLVERR, r)
      wr(8'h44, 32'h0);
      `CHK("bad write", `FBC_RESP_SLVERR, r)
      $display("t_reset done");
    end
  endtask
  task t_ptr;
    begin
      ex(`FBC_OP_SROW, 11'h5);
      ex(`FBC_OP_SCOL, 11'hf);
      rd(`FBC_OFF_PTR);
      `CHK("ptr load", 32'h5f, d)
      ex(`FBC_OP_INCC, 11'h0);
      ex(`FBC_OP_SCOL, 11'h3);
      rd(`FBC_OFF_PTR);
      `CHK("ptr inc", 32'h50, d)
      ex(`FBC_OP_DECC, 11'h0);
      ex(`FBC_OP_NOP, 11'h0);
      rd(`FBC_OFF_PTR);
      `CHK("ptr dec", 32'h5f, d)
      $display("t_ptr done");
    end
  endtask
  task t_ram;
    begin
      ex(`FBC_OP_SROW, 11'h2);
      ex(`FBC_OP_SCOL, 11'h3);
      ex(`FBC_OP_LDI, 11'h9);
      ex(`FBC_OP_STM, 11'h0);
      ex(`FBC_OP_LDI, 11'h0);
      ex(`FBC_OP_LDM, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("ram", 4'h9, d[3:0])
      ex(`FBC_OP_LDI, 11'h7);
      ex(`FBC_OP_WST, 11'h6);
      ex(`FBC_OP_SROW, 11'h5);
      ex(`FBC_OP_SCOL, 11'hf);
      ex(`FBC_OP_LDM, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("flag row", 4'h7, d[3:0])
      $display("t_ram done");
    end
  endtask
  task t_carry;
    begin
      ex(`FBC_OP_SETC, 11'h0);
      ex(`FBC_OP_SAVC, 11'h0);
      ex(`FBC_OP_CLRC, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("saved", 2'b10, d[5:4])
      ex(`FBC_OP_RSTC, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("restored", 2'b11, d[5:4])
      ex(`FBC_OP_CLRC, 11'h0);
      ex(`FBC_OP_LDI, 11'h9);
      ex(`FBC_OP_ADDC, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("add carry", 5'h10, d[4:0])
      $display("t_carry done");
    end
  endtask
  task t_stack;
    integer i;
    reg [32:0] e;
    begin
      ex(`FBC_OP_JUMP, 11'h100);
      ex(`FBC_OP_NOP, 11'h0);
      rd(`FBC_OFF_PC);
      `CHK("pc step", 32'h101, d)
      ex(`FBC_OP_CALL, 11'h200);
      ex(`FBC_OP_CALL, 11'h300);
      ex(`FBC_OP_CALL, 11'h7ff);
      rd(`FBC_OFF_PC);
      `CHK("pc call", 32'h7ff, d)
      rd(`FBC_OFF_STATUS);
      `CHK("depth", 2'h3, d[12:11])
      e = {11'h102, 11'h201, 11'h301};
      for (i = 0; i < 3; i = i + 1) begin
        ex(`FBC_OP_RET, 11'h0);
        rd(`FBC_OFF_PC);
        `CHK("pc ret", e[i*11 +: 11], d[10:0])
      end
      $display("t_stack done");
    end
  endtask
  task t_intr;
    begin
      pulse;
      ex(`FBC_OP_ITEST, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("skip and flag", 3'b100, d[9:7])
      ex(`FBC_OP_NOP, 11'h0);
      wr(`FBC_OFF_INTC, 32'h1);
      pulse;
      rd(`FBC_OFF_PC);
      `CHK("vector", `FBC_INT_VECTOR, d[10:0])
      ex(`FBC_OP_RET, 11'h0);
      rd(`FBC_OFF_PC);
      `CHK("resume", 32'h104, d)
      $display("t_intr done");
    end
  endtask
  task t_timer;
    begin
      ex(`FBC_OP_TSTART, 11'h0);
      ex(`FBC_OP_TSTART, 11'h2);
      rd(`FBC_OFF_TIMER);
      `CHK("count", 6'h2, d[5:0])
      repeat (70) @(posedge aclk);
      rd(`FBC_OFF_TIMER);
      `CHK("count step", 6'h1, d[5:0])
      repeat (70) @(posedge aclk);
      ex(`FBC_OP_TTEST, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("run ff skip", 3'b011, d[10:8])
      ex(`FBC_OP_NOP, 11'h0);
      $display("t_timer done");
    end
  endtask
  task t_ports;
    integer i;
    begin
      pa <= 4'h5;
      pb <= 4'ha;
      d_ext <= 4'hc;
      wr(`FBC_OFF_DIR, 32'h0f);
      for (i = 2; i < 9; i = i + 1) begin
        ex(`FBC_OP_LDI, i[10:0] ^ 11'h9);
        ex(`FBC_OP_POUT, i[10:0]);
      end
      rd(`FBC_OFF_POUT);
      `CHK("pout", 32'h01efcdab, d)
      `CHK("port i", 3'h1, port_i)
      `CHK("d dir", 4'h0, port_d_oe)
      rd(`FBC_OFF_PIN);
      `CHK("pins", 32'hcba5, d)
      ex(`FBC_OP_PIN, {7'h0, `FBC_PSEL_B});
      rd(`FBC_OFF_STATUS);
      `CHK("port b", 4'ha, d[3:0])
      $display("t_ports done");
    end
  endtask
  task t_xch;
    begin
      ex(`FBC_OP_LDI, 11'h6);
      ex(`FBC_OP_WST, 11'h3);
      ex(`FBC_OP_LDI, 11'h3);
      ex(`FBC_OP_A2COL, 11'h0);
      ex(`FBC_OP_LDI, 11'h4);
      ex(`FBC_OP_XCHI, 11'h0);
      ex(`FBC_OP_COL2A, 11'h0);
      rd(`FBC_OFF_STATUS);
      `CHK("col to acc", 4'h4, d[3:0])
      ex(`FBC_OP_LDI, 11'h0);
      ex(`FBC_OP_WLD, 11'h3);
      rd(`FBC_OFF_STATUS);
      `CHK("exchanged", 4'h4, d[3:0])
      $display("t_xch done");
    end
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_ptr;
    t_ram;
    t_carry;
    t_stack;
    t_intr;
    t_timer;
    t_ports;
    t_xch;
    end_sim;
  end
endmodule // test_fbc_core
